/* File: common/sideband_pkg.sv */
package sideband_pkg;

   // Bus and register geometry.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int GPIO_W = 8;
   localparam int PORTS = 4;
   localparam int DEBUG_W = 5;
   localparam int MGMT_ADDR_W = 3;

   // Register byte offsets on the Wishbone slave.
   localparam logic [ADDR_W-1:0] OFS_GPIO_OE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_GPIO_OUT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_GPIO_IN = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STRAPS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_CFG_MEM = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_PORT_STATE = 8'h14;

   // Field positions inside the strap status register.
   localparam int STRAP_CFG_MEM_EN = 0;
   localparam int STRAP_POWER_SAVE = 1;
   localparam int STRAP_PORT_STATE_MODE = 2;
   localparam int STRAP_SMBUS_MODE = 3;
   localparam int STRAP_MGMT_ADDR_LSB = 8;
   localparam int STRAP_DEBUG_LSB = 16;

   // Field positions inside the configuration-memory pin register.
   localparam int CFG_CLOCK_BIT = 0;
   localparam int CFG_DATA_OUT_BIT = 1;
   localparam int CFG_DATA_OE_BIT = 2;
   localparam int CFG_DATA_IN_BIT = 3;

   // Reset values.
   localparam logic [GPIO_W-1:0] GPIO_OE_RESET = 8'h00;
   localparam logic [GPIO_W-1:0] GPIO_OUT_RESET = 8'h00;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

   // Settle count reached after reset release before straps are latched (synchroniser fill).
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // Latched strap values, carried together.
   typedef struct packed {
      logic cfg_mem_enable;
      logic power_save;
      logic port_state_mode;
      logic smbus_mode;
      logic [MGMT_ADDR_W-1:0] mgmt_addr_low;
      logic [DEBUG_W-1:0] debug_select;
   } strap_t;

   // Strap capture sequence.
   typedef enum logic [1:0] {
      ST_SETTLE,
      ST_CAPTURE,
      ST_RUN
   } strap_state_t;

endpackage : sideband_pkg

/* File: core/sideband_pins.sv */
`timescale 1ns/1ps
module sideband_pins (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [sideband_pkg::ADDR_W-1:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [sideband_pkg::DATA_W-1:0] dat_i,
   output logic [sideband_pkg::DATA_W-1:0] dat_o,
   output logic ack_o,
   // Configuration-memory pins.
   output logic cfg_mem_clock_out_o,
   input wire logic cfg_mem_data_io_i,
   output logic cfg_mem_data_io_o,
   output logic cfg_mem_data_io_oe_o,
   // Scan enable pin.
   input wire logic scan_en_i,
   output logic scan_en_o,
   output logic scan_en_oe_o,
   // General-purpose pins.
   input wire logic [sideband_pkg::GPIO_W-1:0] gpio_i,
   output logic [sideband_pkg::GPIO_W-1:0] gpio_o,
   output logic [sideband_pkg::GPIO_W-1:0] gpio_oe_o,
   // Debug mode request from the test pin, and straps.
   input wire logic debug_mode_i,
   input wire logic power_saving_strap_i,
   input wire logic sideband_function_select_i,
   input wire logic smbus_select_strap_i,
   // Management bus pins, passed to the management controller.
   input wire logic mgmt_bus_clock_in_i,
   input wire logic mgmt_bus_data_io_i,
   output logic mgmt_bus_data_io_o,
   output logic mgmt_bus_data_io_oe_o,
   input wire logic mgmt_data_drive_low_i,
   output logic mgmt_clock_sync_o,
   output logic mgmt_data_sync_o,
   // Port status and clock request pins.
   input wire logic [sideband_pkg::PORTS-1:0] port_status_i,
   input wire logic [sideband_pkg::PORTS-1:0] refclk_request_n_i,
   output logic [sideband_pkg::PORTS-1:0] port_state_out_o,
   output logic [sideband_pkg::PORTS-1:0] port_state_out_oe_o,
   output logic [sideband_pkg::PORTS-1:0] refclk_request_n_sync_o,
   // Latched configuration seen by the rest of the switch.
   output sideband_pkg::strap_t straps_o,
   output logic straps_valid_o
);

   // Three-stage synchronisers for every pin that arrives from the board except scan_en_i.
   localparam int SYNC_W = sideband_pkg::GPIO_W + sideband_pkg::PORTS + 7;
   logic [SYNC_W-1:0] raw_in; // Pin levels as they arrive.
   logic [SYNC_W-1:0] sync_a; // First stage, read only by the second.
   logic [SYNC_W-1:0] sync_b; // Second stage.
   logic [SYNC_W-1:0] sync_c; // Third stage.
   logic [SYNC_W-1:0] stable; // Level accepted once stages two and three agree.

   // Register state.
   logic [sideband_pkg::GPIO_W-1:0] gpio_oe; // Direction per pin, 1 drives.
   logic [sideband_pkg::GPIO_W-1:0] gpio_out; // Output levels per pin.
   logic cfg_clock; // Software-driven memory clock level.
   logic cfg_data_out; // Software-driven memory data level.
   logic cfg_data_oe; // Memory data direction.
   sideband_pkg::strap_t straps; // Latched straps.
   sideband_pkg::strap_state_t strap_state; // Capture sequencer.
   logic [1:0] settle_cnt; // Cycles since reset release.
   logic access; // A bus request is pending and not yet answered.
   logic [sideband_pkg::DATA_W-1:0] next_dat; // Read data for the addressed register.

   assign raw_in = {smbus_select_strap_i, sideband_function_select_i, power_saving_strap_i,
                    debug_mode_i, cfg_mem_data_io_i, mgmt_bus_data_io_i, mgmt_bus_clock_in_i,
                    refclk_request_n_i, gpio_i};

   // Shift all raw_in pin levels through three flops.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync_a <= '0;
         sync_b <= '0;
         sync_c <= '0;
      end else begin
         sync_a <= raw_in;
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   // Accept a new level per bit only when the last two stages agree, which filters single-cycle glitches.
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_filter
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               stable[gi] <= 1'b0;
            end else if (sync_b[gi] == sync_c[gi]) begin
               stable[gi] <= sync_c[gi];
            end
         end
      end
   endgenerate

   // Named views of the filtered inputs.
   wire [sideband_pkg::GPIO_W-1:0] gpio_in = stable[sideband_pkg::GPIO_W-1:0];
   wire [sideband_pkg::PORTS-1:0] clkreq_in = stable[sideband_pkg::GPIO_W +: sideband_pkg::PORTS];
   localparam int MISC = sideband_pkg::GPIO_W + sideband_pkg::PORTS;
   wire mgmt_clk_in = stable[MISC];
   wire mgmt_dat_in = stable[MISC+1];
   wire cfg_dat_in = stable[MISC+2];
   wire debug_in = stable[MISC+3];
   wire pwr_in = stable[MISC+4];
   wire sel_in = stable[MISC+5];
   wire smb_in = stable[MISC+6];

   // Strap sequencer: wait for the synchronisers to fill, capture once, then hold until the next reset.
   // The straps share pins with live functions, so they must not follow later pin activity.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         strap_state <= sideband_pkg::ST_SETTLE;
         settle_cnt <= '0;
      end else begin
         unique case (strap_state)
            sideband_pkg::ST_SETTLE: begin
               settle_cnt <= settle_cnt + 2'h1;
               if (settle_cnt == sideband_pkg::STRAP_SETTLE) begin
                  strap_state <= sideband_pkg::ST_CAPTURE;
               end
            end
            sideband_pkg::ST_CAPTURE: begin
               strap_state <= sideband_pkg::ST_RUN;
            end
            sideband_pkg::ST_RUN: begin
               strap_state <= sideband_pkg::ST_RUN; // Held until the next reset.
            end
         endcase
      end
   end

   // Latch the strap levels in the single capture cycle.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         straps <= '0;
      end else if (strap_state == sideband_pkg::ST_CAPTURE) begin
         straps.cfg_mem_enable <= cfg_dat_in;
         straps.power_save <= pwr_in;
         straps.port_state_mode <= sel_in;
         straps.smbus_mode <= smb_in;
         straps.mgmt_addr_low <= gpio_in[sideband_pkg::GPIO_W-1 -: sideband_pkg::MGMT_ADDR_W];
         straps.debug_select <= debug_in ? gpio_in[sideband_pkg::DEBUG_W-1:0] : '0;
      end
   end

   assign straps_o = straps;
   assign straps_valid_o = (strap_state == sideband_pkg::ST_RUN);

   // Debug mode takes the low pins away from general-purpose use; address pins stay inputs.
   wire debug_active = straps_valid_o && debug_in;
   wire [sideband_pkg::GPIO_W-1:0] pin_reserved = {{sideband_pkg::MGMT_ADDR_W{1'b1}},
                                                 {sideband_pkg::DEBUG_W{debug_active}}};

   // Pin drivers. GPIO and memory data stay undriven before the straps are captured so that strap pins read clean; scan enable drives from reset.
   always_comb begin
      gpio_o = gpio_out;
      gpio_oe_o = straps_valid_o ? (gpio_oe & ~pin_reserved) : '0;
      cfg_mem_clock_out_o = cfg_clock;
      cfg_mem_data_io_o = cfg_data_out;
      cfg_mem_data_io_oe_o = straps_valid_o && straps.cfg_mem_enable && cfg_data_oe;
      scan_en_o = 1'b0;
      scan_en_oe_o = 1'b1;
   end

   // Management bus: clock is only received, data is open drain driven low on request.
   assign mgmt_clock_sync_o = mgmt_clk_in;
   assign mgmt_data_sync_o = mgmt_dat_in;
   assign mgmt_bus_data_io_o = 1'b0;
   assign mgmt_bus_data_io_oe_o = mgmt_data_drive_low_i;

   // Shared pins: status outputs in port-state mode, clock request inputs otherwise.
   assign port_state_out_o = port_status_i;
   assign port_state_out_oe_o = {sideband_pkg::PORTS{straps_valid_o && straps.port_state_mode}};
   assign refclk_request_n_sync_o = (straps_valid_o && !straps.port_state_mode) ? clkreq_in
                                    : '1;

   // Wishbone: answer one cycle after the strobe, then drop ack for a cycle.
   assign access = cyc_i && stb_i && !ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= access;
      end
   end

   // Register writes; only byte lane 0 carries data since every register is narrow.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         gpio_oe <= sideband_pkg::GPIO_OE_RESET;
         gpio_out <= sideband_pkg::GPIO_OUT_RESET;
         cfg_clock <= 1'b0;
         cfg_data_out <= 1'b0;
         cfg_data_oe <= 1'b0;
      end else if (access && we_i && sel_i[0]) begin
         unique case (adr_i)
            sideband_pkg::OFS_GPIO_OE: gpio_oe <= dat_i[sideband_pkg::GPIO_W-1:0];
            sideband_pkg::OFS_GPIO_OUT: gpio_out <= dat_i[sideband_pkg::GPIO_W-1:0];
            sideband_pkg::OFS_CFG_MEM: begin
               cfg_clock <= dat_i[sideband_pkg::CFG_CLOCK_BIT];
               cfg_data_out <= dat_i[sideband_pkg::CFG_DATA_OUT_BIT];
               cfg_data_oe <= dat_i[sideband_pkg::CFG_DATA_OE_BIT];
            end
            default: begin
               // Writes to read-only or unmapped addresses are acknowledged and dropped.
            end
         endcase
      end
   end

   // Read multiplexer; unmapped addresses read as zero.
   always_comb begin
      next_dat = sideband_pkg::READ_ZERO;
      unique case (adr_i)
         sideband_pkg::OFS_GPIO_OE: next_dat[sideband_pkg::GPIO_W-1:0] = gpio_oe;
         sideband_pkg::OFS_GPIO_OUT: next_dat[sideband_pkg::GPIO_W-1:0] = gpio_out;
         sideband_pkg::OFS_GPIO_IN: next_dat[sideband_pkg::GPIO_W-1:0] = gpio_in;
         sideband_pkg::OFS_STRAPS: begin
            next_dat[sideband_pkg::STRAP_CFG_MEM_EN] = straps.cfg_mem_enable;
            next_dat[sideband_pkg::STRAP_POWER_SAVE] = straps.power_save;
            next_dat[sideband_pkg::STRAP_PORT_STATE_MODE] = straps.port_state_mode;
            next_dat[sideband_pkg::STRAP_SMBUS_MODE] = straps.smbus_mode;
            next_dat[sideband_pkg::STRAP_MGMT_ADDR_LSB +: sideband_pkg::MGMT_ADDR_W] = straps.mgmt_addr_low;
            next_dat[sideband_pkg::STRAP_DEBUG_LSB +: sideband_pkg::DEBUG_W] = straps.debug_select;
         end
         sideband_pkg::OFS_CFG_MEM: begin
            next_dat[sideband_pkg::CFG_CLOCK_BIT] = cfg_clock;
            next_dat[sideband_pkg::CFG_DATA_OUT_BIT] = cfg_data_out;
            next_dat[sideband_pkg::CFG_DATA_OE_BIT] = cfg_data_oe;
            next_dat[sideband_pkg::CFG_DATA_IN_BIT] = cfg_dat_in;
         end
         sideband_pkg::OFS_PORT_STATE: next_dat[sideband_pkg::PORTS-1:0] = clkreq_in;
         default: next_dat = sideband_pkg::READ_ZERO;
      endcase
   end

   // Read data is registered with the acknowledge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= sideband_pkg::READ_ZERO;
      end else if (access) begin
         dat_o <= next_dat;
      end
   end

endmodule : sideband_pins

/* File: bench/sideband_pins_props.sv */
`timescale 1ns/1ps
// Watches the sideband pin block from its ports only.
module sideband_pins_props (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Observed ports.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic ack_o,
   input wire logic cfg_mem_data_io_oe_o,
   input wire logic scan_en_o,
   input wire logic scan_en_oe_o,
   input wire logic [sideband_pkg::GPIO_W-1:0] gpio_oe_o,
   input wire logic mgmt_bus_data_io_o,
   input wire logic mgmt_bus_data_io_oe_o,
   input wire logic mgmt_data_drive_low_i,
   input wire logic [sideband_pkg::PORTS-1:0] port_status_i,
   input wire logic [sideband_pkg::PORTS-1:0] port_state_out_o,
   input wire logic [sideband_pkg::PORTS-1:0] port_state_out_oe_o,
   input wire logic [sideband_pkg::PORTS-1:0] refclk_request_n_sync_o,
   input wire sideband_pkg::strap_t straps_o,
   input wire logic straps_valid_o
);
   // One clock domain, so clock and reset are given once.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A taken request is answered after one cycle with a single pulse.
   bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
      else $error("Bus answer timing is wrong.");
   scan_drive_a: assert property (!scan_en_o && scan_en_oe_o)
      else $error("Scan enable pin is not driven low.");
   // Once valid, the latched straps never move.
   strap_hold_a: assert property (straps_valid_o |=> straps_valid_o && $stable(straps_o))
      else $error("Latched straps changed.");
   gpio_addr_a: assert property (gpio_oe_o[7:5] == 3'h0)
      else $error("Address pins are driven.");
   gpio_pre_a: assert property (!straps_valid_o |-> gpio_oe_o == 8'h00)
      else $error("Pins driven before straps are latched.");
   cfg_drive_a: assert property (cfg_mem_data_io_oe_o |-> straps_valid_o && straps_o.cfg_mem_enable)
      else $error("Memory data driven while memory is bypassed.");
   port_mode_a: assert property (port_state_out_oe_o == {4{straps_valid_o && straps_o.port_state_mode}}
      && port_state_out_o == port_status_i) else $error("Port status pins wrong.");
   refclk_off_a: assert property (straps_valid_o && straps_o.port_state_mode |-> refclk_request_n_sync_o == 4'hF)
      else $error("Clock requests seen in port status mode.");
   mgmt_drive_a: assert property (mgmt_bus_data_io_oe_o == mgmt_data_drive_low_i && !mgmt_bus_data_io_o)
      else $error("Management data line drive is wrong.");
   // Main scenarios that the bench should reach.
   cover property ($rose(ack_o));
   cover property ($rose(straps_valid_o));
   cover property (port_state_out_oe_o[0]);
endmodule : sideband_pins_props

/* File: bench/sideband_partner.sv */
`timescale 1ns/1ps
// Far side: configuration memory, management host and their pull-ups.
module sideband_partner (
   // Clock.
   input wire logic clk_i,
   // Device pin drivers.
   input wire logic cfg_dev_o_i,
   input wire logic cfg_dev_oe_i,
   input wire logic mgmt_dev_oe_i,
   // Scenario controls.
   input wire logic cfg_tie_i,
   input wire logic host_low_i,
   input wire logic host_clk_en_i,
   // Resolved pin levels.
   output logic cfg_pin_o,
   output logic mgmt_clk_o,
   output logic mgmt_pin_o
);
   // The board tie level shows whenever the device leaves the data line alone.
   assign cfg_pin_o = cfg_dev_oe_i ? cfg_dev_o_i : cfg_tie_i;
   // Open-drain data: either party pulls low, the pull-up wins otherwise.
   assign mgmt_pin_o = !(mgmt_dev_oe_i || host_low_i);
   // Host clock divider, so the clock moves slower than the device's pin filter.
   logic [1:0] div = 2'h0;
   // The host clock rests high between frames, so no stray edges reach the device.
   always_ff @(posedge clk_i) begin
      div <= div + 2'h1;
      mgmt_clk_o <= !host_clk_en_i ? 1'b1 : (div == 2'h3) ? !mgmt_clk_o : mgmt_clk_o;
   end
endmodule : sideband_partner

/* File: bench/tb_strap_and_sideband_pin_control.sv */
`timescale 1ns/1ps
// Self-checking bench: random strap sets, with all-low and all-high corners first.
module tb_strap_and_sideband_pin_control;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, valid;
   logic [7:0] adr = 8'h00, gpio_o, gpio_oe, gpio_pin, tb_gpio = 8'h00, x;
   logic [3:0] sel = 4'h0, pstat = 4'h0, req_n = 4'hF, pout, poe, req_sync;
   logic [31:0] dat = 32'h00000000, dat_o, r;
   logic dbg = 1'b0, ps = 1'b0, sfs = 1'b0, smb = 1'b0, cfg_tie = 1'b1, cfg_clk, cfg_o, cfg_oe, cfg_pin;
   logic host_low = 1'b0, host_clk_en = 1'b0, drive_low = 1'b0, mclk, mpin, mdat_sync, mdrv, mclk_sync, lo;
   logic [15:0] seed = 16'h003C;
   logic [12:0] v;
   sideband_pkg::strap_t straps;
   int n_fail = 0, n_compared = 0, k;
   // Half period of 2 ns gives the 250 MHz clock.
   always #2 clk_i = ~clk_i;
   // Pins not driven by the device show the board level.
   assign gpio_pin = (gpio_oe & gpio_o) | (~gpio_oe & tb_gpio);
   sideband_partner sideband_partner_i (.clk_i(clk_i), .cfg_dev_o_i(cfg_o), .cfg_dev_oe_i(cfg_oe),
      .mgmt_dev_oe_i(mdrv), .cfg_tie_i(cfg_tie), .host_low_i(host_low), .host_clk_en_i(host_clk_en),
      .cfg_pin_o(cfg_pin), .mgmt_clk_o(mclk), .mgmt_pin_o(mpin));
   sideband_pins sideband_pins_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .cfg_mem_clock_out_o(cfg_clk),
      .cfg_mem_data_io_i(cfg_pin), .cfg_mem_data_io_o(cfg_o), .cfg_mem_data_io_oe_o(cfg_oe), .scan_en_i(1'b0),
      .scan_en_o(), .scan_en_oe_o(), .gpio_i(gpio_pin), .gpio_o(gpio_o), .gpio_oe_o(gpio_oe), .debug_mode_i(dbg),
      .power_saving_strap_i(ps), .sideband_function_select_i(sfs), .smbus_select_strap_i(smb),
      .mgmt_bus_clock_in_i(mclk), .mgmt_bus_data_io_i(mpin), .mgmt_bus_data_io_o(), .mgmt_bus_data_io_oe_o(mdrv),
      .mgmt_data_drive_low_i(drive_low), .mgmt_clock_sync_o(mclk_sync), .mgmt_data_sync_o(mdat_sync),
      .port_status_i(pstat), .refclk_request_n_i(req_n), .port_state_out_o(pout), .port_state_out_oe_o(poe),
      .refclk_request_n_sync_o(req_sync), .straps_o(straps), .straps_valid_o(valid));
   // Sixteen-bit shift register for repeatable random values.
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Strap status word expected for a strap set.
   function automatic logic [31:0] strap_word(input logic [12:0] s);
      return {11'h000, s[11] ? s[4:0] : 5'h00, 5'h00, s[7:5], 4'h0, s[10], s[9], s[8], s[12]};
   endfunction : strap_word
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One classic cycle; the request is held until the edge that samples the answer.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= s;
      k = 0;
      do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
      // A bus that never answers counts as a failure.
      if (ack !== 1'b1) n_fail++;
      r = dat_o;
      cyc <= 1'b0; stb <= 1'b0;
      @(posedge clk_i);
   endtask : bus
   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : close_out
   initial begin
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         v = (i == 0) ? 13'h0000 : (i == 1) ? 13'h1FFF : seed[12:0];
         // Straps are applied, then reset runs, so every pass after the first is also a mid-run reset.
         rst_i <= 1'b1; tb_gpio <= v[7:0]; ps <= v[8]; sfs <= v[9]; smb <= v[10]; dbg <= v[11];
         cfg_tie <= v[12]; pstat <= seed[3:0]; req_n <= seed[7:4]; drive_low <= 1'b0; host_low <= 1'b0;
         repeat (20) @(posedge clk_i);
         rst_i <= 1'b0;
         k = 0;
         while (valid !== 1'b1 && k < 30) begin @(posedge clk_i); k++; end
         chk("straps", 32'(straps), 32'({v[12], v[8], v[9], v[10], v[7:5], v[11] ? v[4:0] : 5'h00}));
         // Pins move after the capture; the latched set must not.
         tb_gpio <= ~v[7:0]; ps <= ~v[8]; sfs <= ~v[9]; smb <= ~v[10]; cfg_tie <= ~v[12];
         repeat (8) @(posedge clk_i);
         bus(1'b0, sideband_pkg::OFS_STRAPS, 32'h00000000, 4'hF);
         chk("strap word", r, strap_word(v));
         bus(1'b0, 8'h20, 32'h00000000, 4'hF);
         chk("unmapped", r, 32'h00000000);
         chk("port oe", 32'(poe), 32'({4{v[9]}}));
         chk("port out", 32'(pout), 32'(pstat));
         chk("clock request", 32'(req_sync), 32'(v[9] ? 4'hF : req_n));
         bus(1'b0, sideband_pkg::OFS_PORT_STATE, 32'h00000000, 4'hF);
         chk("request reg", r, 32'(req_n));
         x = seed[15:8];
         bus(1'b1, sideband_pkg::OFS_GPIO_OE, 32'h000000FF, 4'h1);
         bus(1'b1, sideband_pkg::OFS_GPIO_OUT, 32'(x), 4'h1);
         bus(1'b1, sideband_pkg::OFS_GPIO_OUT, 32'(~x), 4'h0);
         chk("gpio out", 32'(gpio_o), 32'(x));
         chk("gpio oe", 32'(gpio_oe), {27'h0000000, v[11] ? 5'h00 : 5'h1F});
         bus(1'b0, sideband_pkg::OFS_GPIO_OE, 32'h00000000, 4'hF);
         chk("oe reg", r, 32'h000000FF);
         bus(1'b0, sideband_pkg::OFS_GPIO_OUT, 32'h00000000, 4'hF);
         chk("out reg", r, 32'(x));
         repeat (6) @(posedge clk_i);
         bus(1'b0, sideband_pkg::OFS_GPIO_IN, 32'h00000000, 4'hF);
         chk("gpio in", r, {24'h000000, v[11] ? ~v[7:0] : {~v[7:5], x[4:0]}});
         bus(1'b1, sideband_pkg::OFS_CFG_MEM, 32'h00000005, 4'h1);
         chk("mem clock", 32'(cfg_clk), 32'h00000001);
         chk("mem oe", 32'(cfg_oe), 32'(v[12]));
         repeat (6) @(posedge clk_i);
         bus(1'b0, sideband_pkg::OFS_CFG_MEM, 32'h00000000, 4'hF);
         chk("mem pins", 32'(r[3:0]), 32'({~v[12], 3'h5}));
         drive_low <= v[0]; host_low <= v[1]; host_clk_en <= 1'b1; lo = 1'b0;
         // The running host clock must reach the filtered copy as a low phase.
         repeat (16) begin @(posedge clk_i); if (mclk_sync === 1'b0) lo = 1'b1; end
         chk("mgmt data", 32'(mdat_sync), 32'(!(v[0] || v[1])));
         chk("mgmt clock low", 32'(lo), 32'h00000001);
         host_clk_en <= 1'b0;
         repeat (8) @(posedge clk_i);
         chk("mgmt clock rest", 32'(mclk_sync), 32'h00000001);
         $display("test %0d done", i);
      end
      close_out();
   end
   // Each pass takes under 150 cycles, so this limit only trips on a hang.
   initial begin
      repeat (5000) @(posedge clk_i);
      n_fail++;
      close_out();
   end
endmodule : tb_strap_and_sideband_pin_control
bind sideband_pins sideband_pins_props sideband_pins_props_i (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o,
   .cfg_mem_data_io_oe_o, .scan_en_o, .scan_en_oe_o, .gpio_oe_o, .mgmt_bus_data_io_o, .mgmt_bus_data_io_oe_o,
   .mgmt_data_drive_low_i, .port_status_i, .port_state_out_o, .port_state_out_oe_o, .refclk_request_n_sync_o,
   .straps_o, .straps_valid_o);
